/* File: pkg/motor_start_stall_pkg.sv */
// constants, register map and states of the motor start/stall monitor
package motor_start_stall_pkg;
    // time base: one tick per millisecond at a 4 ns clock
    localparam int          CLK_PERIOD_NS   = 4;
    localparam int          TICK_PERIOD_NS  = 1000000;
    localparam int          TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int          START_WINDOW_MS = 10;
    localparam logic [3:0]  WINDOW_TICKS    = 4'(START_WINDOW_MS);

    // register byte offsets
    localparam int          ADDR_W          = 6;
    localparam logic [5:0]  REG_CTRL        = 6'h00;
    localparam logic [5:0]  REG_START_TIME  = 6'h04;
    localparam logic [5:0]  REG_HOT_STALL   = 6'h08;
    localparam logic [5:0]  REG_COLD_STALL  = 6'h0c;
    localparam logic [5:0]  REG_CUR_LIMITS  = 6'h10;
    localparam logic [5:0]  REG_NOM_CURRENT = 6'h14;
    localparam logic [5:0]  REG_STATUS      = 6'h18;
    localparam logic [5:0]  REG_IRQ_STATUS  = 6'h1c;
    localparam logic [5:0]  REG_IRQ_MASK    = 6'h20;
    localparam logic [5:0]  REG_ELAPSED     = 6'h24;

    // control bits
    localparam int          CTRL_I2T        = 0;
    localparam int          CTRL_AUTO       = 1;
    localparam int          CTRL_SPEED_USE  = 2;
    localparam int          CTRL_STALL_EN   = 3;
    localparam int          CTRL_JAM_TRIP   = 4;
    localparam int          CTRL_STALL_TRIP = 5;
    localparam int          CTRL_W          = 6;

    // reset values (times in ms, currents in the same units as phase_current)
    localparam logic [5:0]  CTRL_RST        = 6'h00;
    localparam logic [15:0] START_TIME_RST  = 16'h2710;
    localparam logic [15:0] HOT_STALL_RST   = 16'h1388;
    localparam logic [15:0] COLD_STALL_RST  = 16'h2710;
    localparam logic [15:0] NO_LOAD_RST     = 16'h0002;
    localparam logic [15:0] START_DET_RST   = 16'h000f;
    localparam logic [15:0] NOM_CURRENT_RST = 16'h003c;

    // interrupt event bits
    localparam int          EV_START        = 0;
    localparam int          EV_DONE         = 1;
    localparam int          EV_TRIP         = 2;
    localparam int          EV_STALL        = 3;
    localparam int          EV_W            = 4;

    // bus responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_DECERR     = 2'h3;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_WINDOW = 6'h02,
        ST_START  = 6'h04,
        ST_RUN    = 6'h08,
        ST_STALL  = 6'h10,
        ST_TRIP   = 6'h20
    } mon_state_t;
endpackage : motor_start_stall_pkg

/* File: sim/motor_plant.sv */
// motor plant model: breaker, motor current and shaft speed switch
`timescale 1ns/1ps
module motor_plant (
    // clock
    input  wire logic        aclk,
    // bench commands
    input  wire logic [15:0] cur_cmd,
    input  wire logic        spin_cmd,
    // breaker trip from the monitor
    input  wire logic        trip,
    // measurements to the monitor
    output logic [15:0]      phase_current,
    output logic             speed_switch
);
    logic open_brk = 1'b0;
    // breaker opens on trip, recloses only once the contactor is off
    always @(posedge aclk) begin
        if (trip)
            open_brk <= 1'b1;
        else if (cur_cmd == 16'h0000)
            open_brk <= 1'b0;
    end
    // an open breaker leaves no current and a shaft at rest
    assign phase_current = open_brk ? 16'h0000 : cur_cmd;
    assign speed_switch  = spin_cmd & ~open_brk;
endmodule : motor_plant

/* File: sim/motor_start_stall_monitor_tb_top.sv */
// self-checking bench for the motor start/stall monitor
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    err_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module motor_start_stall_monitor_tb_top;
    import motor_start_stall_pkg::*;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
    logic        bready, arvalid, arready, rvalid, rready, speed_switch;
    logic        thermal_hot, trip, mechanical_jam, motor_stalled, irq;
    logic        spin_cmd;
    logic [5:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [15:0] phase_current, cur_cmd;
    logic        thermal_active, thermal_auto_times, thermal_status_valid;
    int          err_count, num_checks;

    // clock and the device under test
    always #2 aclk = ~aclk;
    motor_start_stall_monitor #(.TICK_LEN(10)) dut_u (.aclk, .aresetn,
        .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .phase_current, .speed_switch,
        .thermal_active, .thermal_auto_times, .thermal_status_valid,
        .thermal_hot, .trip, .mechanical_jam, .motor_stalled, .irq);
    motor_plant plant_u (.aclk, .cur_cmd, .spin_cmd, .trip, .phase_current,
        .speed_switch);

    task print_verdict;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    // a bus wait that ran out ends the run
    task tmo(input int n);
        if (n >= 60) begin
            err_count++;
            $display("BAD bus answer exp 1 got 0");
            print_verdict;
        end
    endtask : tmo

    // one write; address and data released as each is taken
    task wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (!bvalid && n < 60);
        bready <= 1'b0;
        tmo(n);
        `CHK("bresp", er, bresp)
    endtask : wr

    // one read, data taken at the edge that sees rvalid
    task rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (!rvalid && n < 60);
        rready <= 1'b0;
        tmo(n);
        `CHK("rdata", e, rdata)
        `CHK("rresp", er, rresp)
    endtask : rd

    // trip must come within the window lo..hi-1 cycles
    task wt(input int lo, input int hi);
        int n;
        n = 0;
        while (trip !== 1'b1 && n < hi) begin
            @(posedge aclk);
            n++;
        end
        `CHK("trip delay in window", 1'b1, n >= lo && n < hi)
        if (n >= hi) print_verdict;
    endtask : wt

    // motor off, breaker reclosed
    task stop;
        cur_cmd <= 16'h0000;
        spin_cmd <= 1'b0;
        repeat (5) @(posedge aclk);
        `CHK("trip released", 1'b0, trip)
    endtask : stop

    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        {spin_cmd, thermal_hot, thermal_active} = 3'h0;
        {thermal_auto_times, thermal_status_valid} = 2'h0;
        {awaddr, araddr, wdata, wstrb, cur_cmd} = '0;
        err_count = 0;
        num_checks = 0;
        wstrb = 4'hf;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values and unmapped places
        rd(REG_START_TIME, 32'h2710, RESP_OKAY);
        rd(REG_CUR_LIMITS, 32'h000f0002, RESP_OKAY);
        rd(REG_NOM_CURRENT, 32'h3c, RESP_OKAY);
        rd(6'h28, 32'h0, RESP_DECERR);
        wr(6'h2c, 32'hffffffff, RESP_DECERR);
        // definite time start that runs too long
        wr(REG_START_TIME, 32'h5, RESP_OKAY);
        wr(REG_IRQ_MASK, 32'h4, RESP_OKAY);
        // slow rise ends in running, not a start
        cur_cmd <= 16'h000a;
        repeat (130) @(posedge aclk);
        rd(REG_STATUS, 32'h8, RESP_OKAY);
        cur_cmd <= 16'h0000;
        repeat (2) @(posedge aclk);
        // fast rise through the window is a start
        cur_cmd <= 16'h000a;
        repeat (3) @(posedge aclk);
        cur_cmd <= 16'h003c;
        wt(35, 70);
        stop;
        `CHK("irq", 1'b1, irq)
        rd(REG_IRQ_STATUS, 32'h5, RESP_OKAY);
        wr(REG_IRQ_STATUS, 32'hf, RESP_OKAY);
        repeat (3) @(posedge aclk);
        `CHK("irq", 1'b0, irq)
        // rotating shaft runs past start time up to hot stall time
        thermal_hot <= 1'b1;
        spin_cmd <= 1'b1;
        wr(REG_HOT_STALL, 32'h14, RESP_OKAY);
        wr(REG_CTRL, 32'h4, RESP_OKAY);
        cur_cmd <= 16'h003c;
        wt(150, 240);
        stop;
        // half current earns four times the start time
        wr(REG_CTRL, 32'h1, RESP_OKAY);
        cur_cmd <= 16'h001e;
        wt(170, 260);
        stop;
        // stall times follow thermal state only while status is delivered
        {thermal_active, thermal_auto_times} <= 2'h3;
        thermal_hot <= 1'b0;
        wr(REG_COLD_STALL, 32'h9, RESP_OKAY);
        wr(REG_CTRL, 32'h2, RESP_OKAY);
        cur_cmd <= 16'h003c;
        wt(35, 70);
        stop;
        thermal_status_valid <= 1'b1;
        cur_cmd <= 16'h003c;
        wt(80, 120);
        stop;
        // stall after a finished start, stalled indication to trip
        wr(REG_CTRL, 32'h28, RESP_OKAY);
        cur_cmd <= 16'h003c;
        repeat (3) @(posedge aclk);
        cur_cmd <= 16'h000a;
        repeat (20) @(posedge aclk);
        cur_cmd <= 16'h003c;
        wt(35, 70);
        `CHK("motor_stalled", 1'b1, motor_stalled)
        `CHK("mechanical_jam", 1'b0, mechanical_jam)
        stop;
        // stall with speed switch in use and shaft at rest is a jam
        wr(REG_CTRL, 32'h1c, RESP_OKAY);
        cur_cmd <= 16'h003c;
        repeat (3) @(posedge aclk);
        cur_cmd <= 16'h000a;
        repeat (20) @(posedge aclk);
        cur_cmd <= 16'h003c;
        wt(35, 70);
        `CHK("mechanical_jam", 1'b1, mechanical_jam)
        stop;
        print_verdict;
    end
endmodule : motor_start_stall_monitor_tb_top

/* File: src/motor_start_stall_monitor.sv */
// motor start / locked rotor supervision with AXI4-Lite registers
`timescale 1ns/1ps
module motor_start_stall_monitor
    import motor_start_stall_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // motor measurements and thermal status
    input  wire logic [15:0]       phase_current,
    input  wire logic              speed_switch,
    input  wire logic              thermal_active,
    input  wire logic              thermal_auto_times,
    input  wire logic              thermal_status_valid,
    input  wire logic              thermal_hot,
    // breaker and indications
    output logic                   trip,
    output logic                   mechanical_jam,
    output logic                   motor_stalled,
    output logic                   irq
);
    function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
        case (a)
            REG_CTRL, REG_START_TIME, REG_HOT_STALL, REG_COLD_STALL,
            REG_CUR_LIMITS, REG_NOM_CURRENT, REG_STATUS,
            REG_IRQ_STATUS, REG_IRQ_MASK, REG_ELAPSED: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : reg_mapped

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        return (old & ~m) | (d & m);
    endfunction : merge

    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic              aw_got;
    logic              w_got;
    logic              do_write;
    logic [CTRL_W-1:0] ctrl;
    logic [15:0]       start_time;
    logic [15:0]       hot_time;
    logic [15:0]       cold_time;
    logic [15:0]       no_load;
    logic [15:0]       start_det;
    logic [15:0]       nom_current;
    logic [EV_W-1:0]   irq_status;
    logic [EV_W-1:0]   irq_mask;
    logic [EV_W-1:0]   events;
    logic              sw_meta;
    logic              sw_sync;
    logic              tick;
    mon_state_t        state;
    mon_state_t        next_state;
    logic [3:0]        win_cnt;
    logic [15:0]       elapsed;
    logic [47:0]       acc;
    logic              cause_start;

    ms_tick_gen #(.TICK_CYCLES(TICK_LEN)) u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick)
    );

    // speed switch pin synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sw_meta <= 1'b0;
            sw_sync <= 1'b0;
        end else begin
            sw_meta <= speed_switch;
            sw_sync <= sw_meta;
        end
    end

    // write channel: address and data taken in either order
    assign do_write = aw_got & w_got & ~bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got  <= 1'b0;
            w_got   <= 1'b0;
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
        end else begin
            awready <= ~aw_got & ~(awvalid & awready) & ~bvalid;
            wready  <= ~w_got & ~(wvalid & wready) & ~bvalid;
            if (awvalid && awready) begin
                aw_got  <= 1'b1;
                wr_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_got   <= 1'b1;
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
            if (do_write) begin
                bvalid <= 1'b1;
                bresp  <= reg_mapped(wr_addr) ? RESP_OKAY : RESP_DECERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
                aw_got <= 1'b0;
                w_got  <= 1'b0;
            end
        end
    end

    // settings registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl        <= CTRL_RST;
            start_time  <= START_TIME_RST;
            hot_time    <= HOT_STALL_RST;
            cold_time   <= COLD_STALL_RST;
            no_load     <= NO_LOAD_RST;
            start_det   <= START_DET_RST;
            nom_current <= NOM_CURRENT_RST;
            irq_mask    <= '0;
        end else if (do_write) begin
            case (wr_addr)
                REG_CTRL: ctrl <= CTRL_W'(merge(32'(ctrl), wr_data,
                                                 wr_strb));
                REG_START_TIME: start_time <= 16'(merge(32'(start_time),
                                                wr_data, wr_strb));
                REG_HOT_STALL: hot_time <= 16'(merge(32'(hot_time),
                                               wr_data, wr_strb));
                REG_COLD_STALL: cold_time <= 16'(merge(32'(cold_time),
                                                wr_data, wr_strb));
                REG_CUR_LIMITS: {start_det, no_load} <= merge(
                                    {start_det, no_load}, wr_data, wr_strb);
                REG_NOM_CURRENT: nom_current <= 16'(merge(
                                     32'(nom_current), wr_data, wr_strb));
                REG_IRQ_MASK: irq_mask <= EV_W'(merge(32'(irq_mask),
                                              wr_data, wr_strb));
                default: ;
            endcase
        end
    end

    // supervision datapath
    logic        above_nl;
    logic        above_sd;
    logic        auto_use;
    logic [15:0] stall_time;
    logic [15:0] max_time;
    logic [31:0] nom_sq;
    logic [31:0] cur_sq;
    logic [47:0] i2t_limit;
    logic        over_limit;
    logic        rotating;
    logic        safe_over;
    logic        trip_now;

    assign above_nl   = phase_current > no_load;
    assign above_sd   = phase_current > start_det;
    assign auto_use   = ctrl[CTRL_AUTO] & thermal_active
                      & thermal_auto_times & thermal_status_valid;
    assign stall_time = thermal_hot ? hot_time : cold_time;
    assign max_time   = auto_use ? stall_time : start_time;
    assign nom_sq     = 32'(nom_current) * 32'(nom_current);
    assign cur_sq     = 32'(phase_current) * 32'(phase_current);
    assign i2t_limit  = 48'(nom_sq) * 48'(max_time);
    assign over_limit = ctrl[CTRL_I2T] ? (acc > i2t_limit)
                                       : (elapsed >= max_time);
    assign rotating   = ctrl[CTRL_SPEED_USE] & sw_sync;
    assign safe_over  = elapsed >= stall_time;
    assign trip_now   = rotating ? safe_over : over_limit;

    // next-state decode
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (above_sd) next_state = ST_START;
                else if (above_nl) next_state = ST_WINDOW;
            ST_WINDOW:
                if (above_sd) next_state = ST_START;
                else if (!above_nl) next_state = ST_IDLE;
                else if (win_cnt >= WINDOW_TICKS) next_state = ST_RUN;
            ST_START:
                if (trip_now) next_state = ST_TRIP;
                else if (!above_sd) next_state = ST_RUN;
            ST_RUN:
                if (!above_nl) next_state = ST_IDLE;
                else if (ctrl[CTRL_STALL_EN] && above_sd)
                    next_state = ST_STALL;
            ST_STALL:
                if (trip_now) next_state = ST_TRIP;
                else if (!above_sd) next_state = ST_RUN;
            ST_TRIP:
                if (!above_nl) next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) state <= ST_IDLE;
        else state <= next_state;
    end

    // start window, elapsed time and I2t accumulator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            win_cnt <= '0;
            elapsed <= '0;
            acc     <= '0;
        end else begin
            win_cnt <= (state != ST_WINDOW) ? 4'h0 : win_cnt + 4'(tick);
            if ((next_state == ST_START && state != ST_START) ||
                (next_state == ST_STALL && state != ST_STALL)) begin
                elapsed <= '0;
                acc     <= '0;
            end else if (tick && (state == ST_START ||
                                  state == ST_STALL)) begin
                if (elapsed != '1) elapsed <= elapsed + 16'h0001;
                acc <= acc + 48'(cur_sq);
            end
        end
    end

    // trip cause and jam / stalled indications
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cause_start    <= 1'b0;
            mechanical_jam <= 1'b0;
            motor_stalled  <= 1'b0;
            trip           <= 1'b0;
        end else begin
            if (state == ST_START && next_state == ST_TRIP)
                cause_start <= 1'b1;
            else if (state == ST_STALL && next_state == ST_TRIP) begin
                motor_stalled  <= 1'b1;
                mechanical_jam <= ctrl[CTRL_SPEED_USE] & ~sw_sync;
            end else if (next_state == ST_IDLE) begin
                cause_start    <= 1'b0;
                motor_stalled  <= 1'b0;
                mechanical_jam <= 1'b0;
            end
            trip <= (state == ST_TRIP) & (cause_start
                    | (mechanical_jam & ctrl[CTRL_JAM_TRIP])
                    | (motor_stalled & ctrl[CTRL_STALL_TRIP]));
        end
    end

    // sticky interrupt status, set wins over write-one-to-clear
    assign events[EV_START] = next_state == ST_START && state != ST_START;
    assign events[EV_DONE]  = state == ST_START && next_state == ST_RUN;
    assign events[EV_TRIP]  = next_state == ST_TRIP && state != ST_TRIP;
    assign events[EV_STALL] = next_state == ST_STALL && state != ST_STALL;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= '0;
            irq        <= 1'b0;
        end else begin
            if (do_write && wr_addr == REG_IRQ_STATUS)
                irq_status <= (irq_status & ~EV_W'(merge(32'h0, wr_data,
                              wr_strb))) | events;
            else
                irq_status <= irq_status | events;
            irq <= |(irq_status & irq_mask);
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= RESP_OKAY;
        end else begin
            arready <= ~rvalid & ~(arvalid & arready);
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp  <= reg_mapped(araddr) ? RESP_OKAY : RESP_DECERR;
                case (araddr)
                    REG_CTRL:        rdata <= 32'(ctrl);
                    REG_START_TIME:  rdata <= 32'(start_time);
                    REG_HOT_STALL:   rdata <= 32'(hot_time);
                    REG_COLD_STALL:  rdata <= 32'(cold_time);
                    REG_CUR_LIMITS:  rdata <= {start_det, no_load};
                    REG_NOM_CURRENT: rdata <= 32'(nom_current);
                    REG_STATUS:      rdata <= 32'({auto_use, sw_sync,
                                                    trip, state});
                    REG_IRQ_STATUS:  rdata <= 32'(irq_status);
                    REG_IRQ_MASK:    rdata <= 32'(irq_mask);
                    REG_ELAPSED:     rdata <= 32'(elapsed);
                    default:         rdata <= 32'h0;
                endcase
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // checks
    sequence s_enter_trip;
        state != ST_TRIP ##1 state == ST_TRIP;
    endsequence
    sequence s_new_start;
        state != ST_START ##1 state == ST_START;
    endsequence

    property p_trip_hold;
        @(posedge aclk) disable iff (!aresetn)
        state == ST_TRIP && above_nl |=> state == ST_TRIP;
    endproperty
    a_trip_hold: assert property (p_trip_hold)
        else $error("trip state left while current flows");

    property p_clear_start;
        @(posedge aclk) disable iff (!aresetn)
        s_new_start |-> elapsed == 16'h0 && acc == 48'h0;
    endproperty
    a_clear_start: assert property (p_clear_start)
        else $error("timers not cleared at start");

    property p_def_trip;
        @(posedge aclk) disable iff (!aresetn)
        state == ST_START && !ctrl[CTRL_I2T] && !rotating
            && elapsed >= max_time |=> state == ST_TRIP ##1 trip;
    endproperty
    a_def_trip: assert property (p_def_trip)
        else $error("definite time start did not trip");

    property p_speed_ext;
        @(posedge aclk) disable iff (!aresetn)
        state == ST_START && over_limit && rotating && !safe_over
            && above_sd |=> state == ST_START;
    endproperty
    a_speed_ext: assert property (p_speed_ext)
        else $error("rotating start was not extended");

    property p_safe_stall;
        @(posedge aclk) disable iff (!aresetn)
        state == ST_START && rotating && safe_over |=> state == ST_TRIP;
    endproperty
    a_safe_stall: assert property (p_safe_stall)
        else $error("safe stall time passed without trip");

    property p_i2t_within;
        @(posedge aclk) disable iff (!aresetn)
        state == ST_START && ctrl[CTRL_I2T] && !rotating && above_sd
            && acc <= i2t_limit |=> state == ST_START;
    endproperty
    a_i2t_within: assert property (p_i2t_within)
        else $error("start stopped inside I2t budget");

    property p_auto_time;
        @(posedge aclk) disable iff (!aresetn)
        !(ctrl[CTRL_AUTO] && thermal_active && thermal_auto_times
            && thermal_status_valid) |-> max_time == start_time;
    endproperty
    a_auto_time: assert property (p_auto_time)
        else $error("stall times used without thermal status");

    property p_start_det;
        @(posedge aclk) disable iff (!aresetn)
        state == ST_WINDOW && above_sd |=> state == ST_START;
    endproperty
    a_start_det: assert property (p_start_det)
        else $error("start within window not recognised");

    property p_stall_sup;
        @(posedge aclk) disable iff (!aresetn)
        state == ST_RUN && ctrl[CTRL_STALL_EN] && above_sd
            |=> state == ST_STALL;
    endproperty
    a_stall_sup: assert property (p_stall_sup)
        else $error("stall not supervised");

    property p_jam_route;
        @(posedge aclk) disable iff (!aresetn)
        s_enter_trip ##0 mechanical_jam && ctrl[CTRL_JAM_TRIP]
            && above_nl |=> trip;
    endproperty
    a_jam_route: assert property (p_jam_route)
        else $error("routed jam did not trip");
endmodule : motor_start_stall_monitor

/* File: src/ms_tick_gen.sv */
// millisecond tick generator for the supervision timers
`timescale 1ns/1ps
module ms_tick_gen #(
    parameter int TICK_CYCLES = 250000
) (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // one-cycle tick
    output logic      tick
);
    localparam int CW = $clog2(TICK_CYCLES);
    localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

    logic [CW-1:0] count;

    // free-running divider, tick on wrap
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (count == LAST) begin
            count <= '0;
            tick  <= 1'b1;
        end else begin
            count <= count + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule : ms_tick_gen
